// ---- src/ftop_port.sv ----
// fifo tagged output port: sample queue read entry by entry over apb
//
// How it works
// - a read-only 8-bit tag register holds source id in bits 7..3, slot counter in 2..1, parity in bit 0.
// - the source id names the sensor of the entry, codes 01h to 05h for the plain sources.
// - codes 06h..0Dh are compressed and delta variants, 0Eh..11h hub slaves, 12h step counter, 19h hub nack.
// - the two-bit slot counter of each tag carries the time slot the entry was captured in.
// - the least significant tag bit is a parity check over the tag content.
// - the first word reads as a low byte register and a high byte register.
// - the second word reads as a low byte register and a high byte register.
// - the third word reads as a low byte register and a high byte register.
`include "ftop_consts.svh"
`default_nettype none

module ftop_port
    import ftop_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int AW    = 12
) (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // apb slave
    input  wire logic [AW-1:0] paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    // sample input
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire ftop_sample_t  in_sample
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam int EW = $bits(ftop_entry_t);
    localparam int SW = $bits(ftop_sample_t);

    // buffer outlet
    logic          buf_valid;
    logic          buf_ready;
    ftop_sample_t  buf_sample;

    // queue state
    logic [CW-1:0] wr_ptr_q;
    logic [CW-1:0] rd_ptr_q;
    logic [CW-1:0] level;
    logic          q_full;
    logic          q_empty;
    logic          q_push;
    logic          q_pop;
    ftop_entry_t   new_entry;
    ftop_entry_t   mem_rd_data;

    // current entry
    ftop_fetch_t   fetch_q;
    ftop_fetch_t   fetch_d;
    ftop_entry_t   cur_q;
    logic          cur_valid;
    logic [7:0]    cur_bytes [7];

    // control and status
    logic          accept_q;
    logic          bad_q;
    logic          code_ok;
    logic          flush;
    logic          clr_bad;

    // bus
    logic          acc;
    logic          done;
    logic [7:0]    idx;
    logic          addr_ok;
    logic          rd_hit;
    logic          wr_hit;
    logic [31:0]   rd_word;
    logic          pready_q;
    logic          last_byte;
    logic          ctrl_hit;
    logic          stat_hit;
    logic          ctrl_wr;
    logic [6:0]    data_hit;
    logic [7:0]    data_byte;
    logic [31:0]   stat_word;

    // known source codes
    function automatic logic src_known(input logic [4:0] code);
        logic ok;
        ok = 1'b0;
        case (code)
            SRC_GYRO_NC, SRC_ACC_NC, SRC_TEMP, SRC_TIMESTAMP, SRC_CFG_CHANGE: begin
                ok = 1'b1;
            end
            SRC_ACC_NC_T2, SRC_ACC_NC_T1, SRC_ACC_DOUBLE, SRC_ACC_TRIPLE,
            SRC_GYRO_NC_T2, SRC_GYRO_NC_T1, SRC_GYRO_DOUBLE, SRC_GYRO_TRIPLE,
            SRC_HUB_SLAVE0, SRC_HUB_SLAVE1, SRC_HUB_SLAVE2, SRC_HUB_SLAVE3,
            SRC_STEP_COUNTER, SRC_HUB_NACK: begin
                ok = 1'b1;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    // input staging buffer
    ftop_buf #(
        .W       (SW)
    ) u_buf (
        .clk     (pclk),
        .rst_n   (presetn),
        .s_valid (in_valid),
        .s_ready (in_ready),
        .s_data  (in_sample),
        .m_valid (buf_valid),
        .m_ready (buf_ready),
        .m_data  (buf_sample)
    );

    // build the stored entry with its tag
    assign code_ok                    = src_known(buf_sample.source);
    assign new_entry.tag.source       = buf_sample.source;
    assign new_entry.tag.slot_counter = buf_sample.slot_counter;
    assign new_entry.tag.parity       = ^{buf_sample.source, buf_sample.slot_counter};
    assign new_entry.words            = buf_sample.words;

    // queue bookkeeping
    assign level   = wr_ptr_q - rd_ptr_q;
    assign q_full  = (level == CW'(DEPTH));
    assign q_empty = (level == '0);

    // unknown codes are dropped, known ones wait for room
    assign buf_ready = accept_q & ~flush & (~code_ok | ~q_full);
    assign q_push    = buf_valid & buf_ready & code_ok;
    assign q_pop     = (fetch_q == FETCH_EMPTY) & ~q_empty & ~flush;

    ftop_mem #(
        .W       (EW),
        .DEPTH   (DEPTH),
        .AW      (PW)
    ) u_mem (
        .clk     (pclk),
        .rst_n   (presetn),
        .wr_en   (q_push),
        .wr_addr (wr_ptr_q[PW-1:0]),
        .wr_data (new_entry),
        .rd_en   (q_pop),
        .rd_addr (rd_ptr_q[PW-1:0]),
        .rd_data (mem_rd_data)
    );

    // write pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= '0;
        end else if (flush) begin
            wr_ptr_q <= '0;
        end else if (q_push) begin
            wr_ptr_q <= wr_ptr_q + CW'(1);
        end
    end

    // read pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_q <= '0;
        end else if (flush) begin
            rd_ptr_q <= '0;
        end else if (q_pop) begin
            rd_ptr_q <= rd_ptr_q + CW'(1);
        end
    end

    // apb decode
    assign idx     = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[AW-1:10] == '0);
    assign acc     = psel & penable & ~pready_q;
    assign done    = psel & penable & pready_q;
    assign pready  = pready_q;

    // register hits
    assign ctrl_hit = addr_ok & (idx == `FTOP_IDX_CTRL);
    assign stat_hit = addr_ok & (idx == `FTOP_IDX_STAT);
    assign ctrl_wr  = done & pwrite & ctrl_hit;

    // one hit per entry byte register
    for (genvar b = 0; b < 7; b++) begin : g_hit
        assign data_hit[b] = addr_ok & (idx == (`FTOP_IDX_TAG + 8'(b)));
    end

    assign last_byte = done & ~pwrite & data_hit[6];
    assign flush     = ctrl_wr & pwdata[`FTOP_CTRL_FLUSH];
    assign clr_bad   = ctrl_wr & pwdata[`FTOP_CTRL_CLR_BAD];

    // fetch state machine
    always_comb begin
        fetch_d = fetch_q;
        case (fetch_q)
            FETCH_EMPTY: begin
                if (q_pop) begin
                    fetch_d = FETCH_WAIT;
                end
            end
            FETCH_WAIT: begin
                fetch_d = FETCH_HOLD;
            end
            FETCH_HOLD: begin
                if (last_byte) begin
                    fetch_d = FETCH_EMPTY;
                end
            end
            default: begin
                fetch_d = FETCH_EMPTY;
            end
        endcase
        if (flush) begin
            fetch_d = FETCH_EMPTY;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_q <= FETCH_EMPTY;
        end else begin
            fetch_q <= fetch_d;
        end
    end

    // current entry capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_q <= '0;
        end else if (flush) begin
            cur_q <= '0;
        end else if (fetch_q == FETCH_WAIT) begin
            cur_q <= mem_rd_data;
        end
    end

    assign cur_valid = (fetch_q == FETCH_HOLD);

    // byte view of the current entry
    assign cur_bytes[0] = cur_valid ? cur_q.tag : 8'h00;
    for (genvar w = 0; w < 3; w++) begin : g_word
        assign cur_bytes[2*w+1] = cur_valid ? cur_q.words[w][7:0] : 8'h00;
        assign cur_bytes[2*w+2] = cur_valid ? cur_q.words[w][15:8] : 8'h00;
    end

    // accept enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accept_q <= `FTOP_CTRL_RESET;
        end else if (ctrl_wr) begin
            accept_q <= pwdata[`FTOP_CTRL_ACCEPT];
        end
    end

    // sticky unknown-code flag, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad_q <= 1'b0;
        end else if (buf_valid && buf_ready && !code_ok) begin
            bad_q <= 1'b1;
        end else if (clr_bad) begin
            bad_q <= 1'b0;
        end
    end

    // entry byte picked by its hit
    always_comb begin
        data_byte = 8'h00;
        for (int i = 0; i < 7; i++) begin
            if (data_hit[i]) begin
                data_byte = data_byte | cur_bytes[i];
            end
        end
    end

    // status word
    always_comb begin
        stat_word                         = 32'h0000_0000;
        stat_word[`FTOP_STAT_VALID]       = cur_valid;
        stat_word[`FTOP_STAT_BAD]         = bad_q;
        stat_word[`FTOP_STAT_LEVEL +: CW] = level;
    end

    // read mux and access check
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b0;
        wr_hit  = 1'b0;
        if (|data_hit) begin
            rd_hit  = 1'b1;
            rd_word = {24'h00_0000, data_byte};
        end else if (ctrl_hit) begin
            rd_hit  = 1'b1;
            wr_hit  = 1'b1;
            rd_word = 32'(accept_q);
        end else if (stat_hit) begin
            rd_hit  = 1'b1;
            rd_word = stat_word;
        end
    end

    // bus answer after one wait cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= acc;
        end
    end

    // read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (acc) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_word;
        end
    end

    // error response register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (acc) begin
            pslverr <= pwrite ? ~wr_hit : ~rd_hit;
        end
    end

endmodule

`default_nettype wire

// ---- inc/ftop_consts.svh ----
// register indices, field positions and reset values of the fifo tagged output port
`ifndef FTOP_CONSTS_SVH
`define FTOP_CONSTS_SVH

// register indices; byte address is four times the index
`define FTOP_IDX_TAG        8'h78
`define FTOP_IDX_W0_LOW     8'h79
`define FTOP_IDX_W0_HIGH    8'h7A
`define FTOP_IDX_W1_LOW     8'h7B
`define FTOP_IDX_W1_HIGH    8'h7C
`define FTOP_IDX_W2_LOW     8'h7D
`define FTOP_IDX_W2_HIGH    8'h7E
`define FTOP_IDX_CTRL       8'h40
`define FTOP_IDX_STAT       8'h41

// control fields
`define FTOP_CTRL_ACCEPT    0
`define FTOP_CTRL_FLUSH     1
`define FTOP_CTRL_CLR_BAD   2
`define FTOP_CTRL_RESET     1'b1

// status fields
`define FTOP_STAT_VALID     0
`define FTOP_STAT_BAD       1
`define FTOP_STAT_LEVEL     8

// tag fields
`define FTOP_TAG_SRC_LSB    3
`define FTOP_TAG_SLOT_LSB   1
`define FTOP_TAG_PARITY     0

// bus timing: wait cycles before pready
`define FTOP_WAIT_CYCLES    1

`endif

// ---- inc/ftop_pkg.sv ----
// types shared by the fifo tagged output port
`default_nettype none

package ftop_pkg;

    // sample source codes
    typedef enum logic [4:0] {
        SRC_GYRO_NC       = 5'h01,
        SRC_ACC_NC        = 5'h02,
        SRC_TEMP          = 5'h03,
        SRC_TIMESTAMP     = 5'h04,
        SRC_CFG_CHANGE    = 5'h05,
        SRC_ACC_NC_T2     = 5'h06,
        SRC_ACC_NC_T1     = 5'h07,
        SRC_ACC_DOUBLE    = 5'h08,
        SRC_ACC_TRIPLE    = 5'h09,
        SRC_GYRO_NC_T2    = 5'h0A,
        SRC_GYRO_NC_T1    = 5'h0B,
        SRC_GYRO_DOUBLE   = 5'h0C,
        SRC_GYRO_TRIPLE   = 5'h0D,
        SRC_HUB_SLAVE0    = 5'h0E,
        SRC_HUB_SLAVE1    = 5'h0F,
        SRC_HUB_SLAVE2    = 5'h10,
        SRC_HUB_SLAVE3    = 5'h11,
        SRC_STEP_COUNTER  = 5'h12,
        SRC_HUB_NACK      = 5'h19
    } ftop_src_t;

    // 8-bit entry tag
    typedef struct packed {
        logic [4:0] source;
        logic [1:0] slot_counter;
        logic       parity;
    } ftop_tag_t;

    // sample offered by the write side
    typedef struct packed {
        logic [4:0]       source;
        logic [1:0]       slot_counter;
        logic [2:0][15:0] words;
    } ftop_sample_t;

    // stored fifo entry
    typedef struct packed {
        ftop_tag_t        tag;
        logic [2:0][15:0] words;
    } ftop_entry_t;

    // entry fetch states
    typedef enum logic [1:0] {
        FETCH_EMPTY = 2'b00,
        FETCH_WAIT  = 2'b01,
        FETCH_HOLD  = 2'b10
    } ftop_fetch_t;

endpackage

`default_nettype wire

// ---- src/ftop_mem.sv ----
// entry storage with registered read data
`default_nettype none

module ftop_mem #(
    parameter int W     = 56,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // read port
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic [W-1:0]       rd_data
);

    logic [W-1:0] mem_q [DEPTH];

    // storage array
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // read register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem_q[rd_addr];
        end
    end

endmodule

`default_nettype wire

// ---- src/ftop_buf.sv ----
// two-entry buffer with valid and ready on both sides
`default_nettype none

module ftop_buf #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // filling side
    input  wire logic         s_valid,
    output logic              s_ready,
    input  wire logic [W-1:0] s_data,
    // draining side
    output logic              m_valid,
    input  wire logic         m_ready,
    output logic [W-1:0]      m_data
);

    logic [1:0][W-1:0] slot_q;
    logic [1:0]        cnt_q;
    logic              wr_q;
    logic              rd_q;
    logic              push;
    logic              pop;

    assign s_ready = (cnt_q != 2'd2);
    assign m_valid = (cnt_q != 2'd0);
    assign m_data  = slot_q[rd_q];
    assign push    = s_valid & s_ready;
    assign pop     = m_valid & m_ready;

    // entry storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_q <= '0;
        end else if (push) begin
            slot_q[wr_q] <= s_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'd1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'd1;
            end
        end
    end

endmodule

`default_nettype wire

// ---- test/ftop_monitor.sv ----
// apb answer checker of the fifo tagged output port
`default_nettype none

module ftop_monitor #(
    parameter int AW = 12
) (
    // clock and reset
    input wire logic          pclk,
    input wire logic          presetn,
    // apb
    input wire logic [AW-1:0] paddr,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic          pready,
    input wire logic [31:0]   prdata,
    input wire logic          pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_one_wait:
        assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("no answer after one wait");
    a_ready_pulse:
        assert property (pready |=> !pready)
        else $error("pready too long");
    a_err_zero:
        assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error with data");
    a_bad_align:
        assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned accepted");
    a_ro_refused:
        assert property (pready && pwrite && paddr >= 12'h1E0 && paddr <= 12'h1F8 |-> pslverr)
        else $error("read-only write accepted");
    a_tag_parity:
        assert property (pready && !pwrite && !pslverr && paddr == 12'h1E0 |-> !(^prdata))
        else $error("odd tag parity");
    a_tag_source:
        assert property (pready && !pwrite && paddr == 12'h1E0 && prdata != 32'h0
            |-> prdata[7:3] inside {[5'h01:5'h12], 5'h19})
        else $error("unknown source in tag");
    a_byte_width:
        assert property (pready && !pwrite && paddr >= 12'h1E0 && paddr <= 12'h1F8 |-> prdata[31:8] == 24'h0)
        else $error("register wider than a byte");
endmodule

bind ftop_port ftop_monitor #(.AW(AW)) ftop_monitor_i (
    .pclk    (pclk),
    .presetn (presetn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr)
);

`default_nettype wire

// ---- test/ftop_src_model.sv ----
// sample source model feeding the port
`default_nettype none

module ftop_src_model
    import ftop_pkg::*;
(
    // clock and reset
    input wire logic    pclk,
    input wire logic    presetn,
    // sample stream
    output logic        in_valid,
    input wire logic    in_ready,
    output ftop_sample_t in_sample
);
    ftop_sample_t q[$];

    task automatic push(input ftop_sample_t s);
        q.push_back(s);
    endtask

    // holds each sample until taken, scrambles data when idle
    always @(posedge pclk) begin
        if (!presetn) begin
            in_valid <= 1'b0;
            in_sample <= '0;
        end else if (!in_valid || in_ready) begin
            if (q.size() > 0) begin
                in_valid <= 1'b1;
                in_sample <= q.pop_front();
            end else begin
                in_valid <= 1'b0;
                in_sample <= ~in_sample;
            end
        end
    end
endmodule

`default_nettype wire

// ---- test/tb_fifo_tagged_output_port.sv ----
// testbench of the fifo tagged output port
`include "ftop_consts.svh"
`default_nettype none

module tb_fifo_tagged_output_port
    import ftop_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [4:0] CODES [19] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
        5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h19};
    localparam logic [11:0] BAD [3] = '{12'h040, 12'h1E1, 12'h5E0};

    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [31:0]  pwdata = 32'h0;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
    logic         in_valid;
    logic         in_ready;
    ftop_sample_t in_sample;
    ftop_sample_t exp_q[$];
    logic [31:0]  r;
    logic         e;
    int           err_count = 0;
    int           total_checks = 0;

    always #25 pclk = ~pclk;

    ftop_port #(.DEPTH(16), .AW(12)) ftop_port_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .paddr     (paddr),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .pwdata    (pwdata),
        .pready    (pready),
        .prdata    (prdata),
        .pslverr   (pslverr),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_sample (in_sample)
    );

    ftop_src_model ftop_src_model_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_sample (in_sample)
    );

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    function automatic logic [7:0] byt(input ftop_sample_t x, input int i);
        return x.words[i / 2][8 * (i % 2) +: 8];
    endfunction

    task automatic summarize();
        if (err_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [32:0] x, input logic [32:0] g);
        total_checks++;
        if (g !== x) begin
            $display("[FAIL] %s expected %h seen %h", n, x, g);
            err_count++;
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            summarize();
        end
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] x, input string n);
        apb(ba(idx), 1'b0, 32'h0);
        chk(n, {1'b0, x}, {e, r});
    endtask

    task automatic wt();
        int n;
        n = 0;
        do begin
            apb(ba(`FTOP_IDX_STAT), 1'b0, 32'h0);
            n++;
        end while (r[0] !== 1'b1 && n < 20);
        if (r[0] !== 1'b1) begin
            err_count++;
            summarize();
        end
    endtask

    task automatic send(input logic [4:0] s, input logic [1:0] c, input logic [15:0] k, input bit keep);
        ftop_sample_t x;
        x.source = s;
        x.slot_counter = c;
        x.words = {k ^ 16'h0F0F, k + 16'h1111, k};
        ftop_src_model_i.push(x);
        if (keep)
            exp_q.push_back(x);
    endtask

    task automatic entry();
        ftop_sample_t x;
        x = exp_q.pop_front();
        rd(`FTOP_IDX_TAG, {24'h0, x.source, x.slot_counter, ^{x.source, x.slot_counter}}, "tag");
        for (int i = 0; i < 6; i++)
            rd(`FTOP_IDX_W0_LOW + 8'(i), {24'h0, byt(x, i)}, "data byte");
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("ready after reset", 33'h1, {32'h0, in_ready});
        rd(`FTOP_IDX_TAG, 32'h0, "tag at reset");
        rd(`FTOP_IDX_CTRL, 32'h1, "ctrl at reset");
        rd(`FTOP_IDX_STAT, 32'h0, "stat at reset");
        for (int i = 0; i < 19; i++) begin
            send(CODES[i], 2'(i), 16'h1357 * 16'(i + 1), 1'b1);
            wt();
            entry();
        end
        // partial reads keep the entry
        send(5'h01, 2'h1, 16'hA55A, 1'b1);
        send(5'h02, 2'h2, 16'h5AA5, 1'b1);
        wt();
        for (int i = 0; i < 5; i++)
            rd(`FTOP_IDX_W0_LOW + 8'(i), {24'h0, byt(exp_q[0], i)}, "early byte");
        entry();
        wt();
        entry();
        // undefined source dropped and flagged
        send(5'h15, 2'h0, 16'h0, 1'b0);
        repeat (8) @(posedge pclk);
        rd(`FTOP_IDX_STAT, 32'h2, "stat unknown");
        apb(ba(`FTOP_IDX_CTRL), 1'b1, 32'h5);
        rd(`FTOP_IDX_STAT, 32'h0, "stat cleared");
        // refused accesses
        apb(ba(`FTOP_IDX_TAG), 1'b1, 32'hFF);
        chk("read-only write", {1'b1, 32'h0}, {e, r});
        for (int i = 0; i < 3; i++) begin
            apb(BAD[i], 1'b0, 32'h0);
            chk("bad address", {1'b1, 32'h0}, {e, r});
        end
        // buffer fills while the queue is closed
        apb(ba(`FTOP_IDX_CTRL), 1'b1, 32'h0);
        for (int i = 0; i < 3; i++)
            send(5'h03, 2'(i), 16'h0101 * 16'(i + 1), 1'b1);
        repeat (6) @(posedge pclk);
        chk("stalled stream", 33'h2, {31'h0, in_valid, in_ready});
        rd(`FTOP_IDX_STAT, 32'h0, "stat closed");
        apb(ba(`FTOP_IDX_CTRL), 1'b1, 32'h1);
        repeat (3) begin
            wt();
            entry();
        end
        // flush drops the held entry
        send(5'h04, 2'h3, 16'hBEEF, 1'b0);
        wt();
        apb(ba(`FTOP_IDX_CTRL), 1'b1, 32'h3);
        rd(`FTOP_IDX_STAT, 32'h0, "stat flushed");
        rd(`FTOP_IDX_TAG, 32'h0, "tag flushed");
        // reset in mid-run drops the held entry and restores control
        send(5'h02, 2'h1, 16'h1234, 1'b0);
        wt();
        apb(ba(`FTOP_IDX_CTRL), 1'b1, 32'h0);
        repeat (2) @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`FTOP_IDX_CTRL, 32'h1, "ctrl after reset");
        rd(`FTOP_IDX_STAT, 32'h0, "stat after reset");
        rd(`FTOP_IDX_TAG, 32'h0, "tag after reset");
        summarize();
    end
endmodule

`default_nettype wire
